/* File: core/dbsp_port.sv */
// Purpose: ddr burst-of-two static memory port, device side
// Assumes: output clock pair, when used, is edge aligned with the input pair
// Notes:   i_clock only carries the access monitor
//
// Summary of operation
// - one address per burst, taken only on alternate input clock rises
// - write words taken on rising true clock then rising complement clock
// - read data launched on output clock pair, else on input clock pair
// - only rising edges of each clock are used
// - one-bit burst counter loads start bit; two words per access
// - latency pin high gives read data one and a half cycles after address
// - latency pin low gives read data one cycle after address
// - all synchronous inputs pass input registers on the input clock pair
// - two echo clocks run aligned with the read data
// - array write completes internally, no strobe needed from controller
// - depth 1M by 18 or 512K by 36, address sized to match
// - byte selects sampled with each data word; deselected bytes unchanged
// - data pins released whenever no read is active
// - burst address bit advances linearly from the supplied start bit
`timescale 1ns/10ps
module dbsp_port
	import dbsp_pkg::*;
#(
	parameter int unsigned DATA_W = DBSP_DATA_W_NARROW,
	parameter int unsigned ADDR_W = DBSP_ADDR_W_NARROW
) (
	input  wire logic                            i_clock,
	input  wire logic                            i_rst_n,
	input  wire logic                            i_k_clk,
	input  wire logic                            i_k_clk_n,
	input  wire logic                            i_c_clk,
	input  wire logic                            i_c_clk_n,
	input  wire logic                            i_out_clk_sel,
	input  wire logic                            i_latency_mode_pin,
	input  wire logic                            i_access_load_n,
	input  wire logic                            i_rd_wr_n,
	input  wire logic [ADDR_W-2:0]               i_addr,
	input  wire logic                            i_burst_start_bit,
	input  wire logic [DATA_W/DBSP_BYTE_W-1:0]   i_byte_write_sel_n,
	input  wire logic [DATA_W-1:0]               i_dq,
	output logic      [DATA_W-1:0]               o_dq,
	output logic                                 o_dq_oe,
	output logic                                 o_echo_strobe,
	output logic                                 o_echo_strobe_n,
	output logic                                 o_access_pulse,
	output logic      [DBSP_CNT_W-1:0]           o_access_count
);

	// ----------------------------------------------------------------
	// derived sizes
	// ----------------------------------------------------------------
	localparam int unsigned NBYTES = DATA_W / DBSP_BYTE_W;
	localparam int unsigned ROW_W  = ADDR_W - 1;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// returns {second, first} word pair for a given start bit
	function automatic logic [2*DATA_W-1:0] f_order(
		input logic [DATA_W-1:0] w_a,
		input logic [DATA_W-1:0] w_b,
		input logic              swap
	);
		f_order = swap ? {w_a, w_b} : {w_b, w_a};
	endfunction

	function automatic logic [2*NBYTES-1:0] f_order_be(
		input logic [NBYTES-1:0] b_a,
		input logic [NBYTES-1:0] b_b,
		input logic              swap
	);
		f_order_be = swap ? {b_a, b_b} : {b_b, b_a};
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                  lclk;
	logic                  lclk_n;
	logic                  accept;
	logic                  last_ld_reg;
	logic                  mode_m_reg;
	dbsp_lat_t             mode_reg;
	logic                  acc_tgl_reg;
	logic                  wr_cmd_reg;
	logic [ROW_W-1:0]      wr_row_reg;
	logic                  wr_a0_reg;
	logic                  wr_pend_reg;
	logic [ROW_W-1:0]      wr_row2_reg;
	logic                  wr_a0_2_reg;
	logic [DATA_W-1:0]     wd0_reg;
	logic [NBYTES-1:0]     wb0_reg;
	logic [DATA_W-1:0]     wd1_reg;
	logic [NBYTES-1:0]     wb1_reg;
	logic                  rd_s0_reg;
	logic                  rd_s1_reg;
	logic                  rd_a0_reg;
	logic [DATA_W-1:0]     rw0;
	logic [DATA_W-1:0]     rw1;
	logic [DATA_W-1:0]     q_rise_reg;
	logic                  oe_rise_reg;
	logic [DATA_W-1:0]     q_fall_reg;
	logic                  oe_fall_reg;
	logic                  tg_m_reg;
	logic                  tg_s_reg;
	logic                  tg_d_reg;
	logic                  pulse_reg;
	logic [DBSP_CNT_W-1:0] count_reg;

	dbsp_mem_if #(
		.DATA_W (DATA_W),
		.NBYTES (NBYTES),
		.ROW_W  (ROW_W)
	) mif ();

	// ----------------------------------------------------------------
	// launch clock selection
	// ----------------------------------------------------------------
	// output pair or input pair
	assign lclk   = i_out_clk_sel ? i_c_clk   : i_k_clk;
	assign lclk_n = i_out_clk_sel ? i_c_clk_n : i_k_clk_n;

	// ----------------------------------------------------------------
	// command acceptance, input clock domain
	// ----------------------------------------------------------------
	// alternate edges only
	assign accept = ~i_access_load_n & ~last_ld_reg;

	always_ff @(posedge i_k_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_ld_reg <= 1'b0;
		end else begin
			last_ld_reg <= accept;
		end
	end

	// strap level from a pin, two flops before use
	always_ff @(posedge i_k_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_m_reg <= DBSP_LAT_RST;
			mode_reg   <= DBSP_LAT_RST;
		end else begin
			mode_m_reg <= i_latency_mode_pin;
			mode_reg   <= dbsp_lat_t'(mode_m_reg);
		end
	end

	// event toggle toward the monitor clock
	always_ff @(posedge i_k_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_tgl_reg <= 1'b0;
		end else if (accept) begin
			acc_tgl_reg <= ~acc_tgl_reg;
		end
	end

	// ----------------------------------------------------------------
	// write path
	// ----------------------------------------------------------------
	// address register
	always_ff @(posedge i_k_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_cmd_reg <= 1'b0;
			wr_row_reg <= '0;
			wr_a0_reg  <= 1'b0;
		end else begin
			wr_cmd_reg <= accept & ~i_rd_wr_n;
			if (accept) begin
				wr_row_reg <= i_addr;
				wr_a0_reg  <= i_burst_start_bit;
			end
		end
	end

	// first word on true clock rise
	always_ff @(posedge i_k_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_pend_reg <= 1'b0;
			wr_row2_reg <= '0;
			wr_a0_2_reg <= 1'b0;
			wd0_reg     <= '0;
			wb0_reg     <= '0;
		end else begin
			wr_pend_reg <= wr_cmd_reg;
			if (wr_cmd_reg) begin
				wr_row2_reg <= wr_row_reg;
				wr_a0_2_reg <= wr_a0_reg;
				wd0_reg     <= i_dq;
				wb0_reg     <= ~i_byte_write_sel_n;
			end
		end
	end

	always_ff @(posedge i_k_clk_n or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wd1_reg <= '0;
			wb1_reg <= '0;
		end else begin
			wd1_reg <= i_dq;
			wb1_reg <= ~i_byte_write_sel_n;
		end
	end

	// second word to toggled bit
	// a read of the same row in the commit cycle returns old data
	assign mif.wr_en  = wr_pend_reg;
	assign mif.wr_row = wr_row2_reg;
	assign {mif.wr_odd, mif.wr_even} = f_order(wd0_reg, wd1_reg, wr_a0_2_reg);
	assign {mif.be_odd, mif.be_even} = f_order_be(wb0_reg, wb1_reg, wr_a0_2_reg);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// array read register samples the address
	assign mif.rd_en  = accept & i_rd_wr_n;
	assign mif.rd_row = i_addr;

	always_ff @(posedge i_k_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_s0_reg <= 1'b0;
			rd_s1_reg <= 1'b0;
			rd_a0_reg <= 1'b0;
		end else begin
			rd_s0_reg <= mif.rd_en;
			rd_s1_reg <= rd_s0_reg;
			if (mif.rd_en) begin
				rd_a0_reg <= i_burst_start_bit;
			end
		end
	end

	assign {rw1, rw0} = f_order(mif.rd_even, mif.rd_odd, rd_a0_reg);

	dbsp_burst_mem #(
		.DATA_W (DATA_W),
		.NBYTES (NBYTES),
		.ROW_W  (ROW_W)
	) u_mem (
		.i_clk (i_k_clk),
		.mif   (mif.mem)
	);

	// ----------------------------------------------------------------
	// output launch
	// ----------------------------------------------------------------
	// launch clock rise: first word in one-cycle mode, second word in one-and-a-half mode
	always_ff @(posedge lclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_rise_reg  <= '0;
			oe_rise_reg <= 1'b0;
		end else if (mode_reg == DBSP_LAT_ONE_HALF) begin
			q_rise_reg  <= rw1;
			oe_rise_reg <= rd_s1_reg;
		end else begin
			q_rise_reg  <= rw0;
			oe_rise_reg <= rd_s0_reg;
		end
	end

	always_ff @(posedge lclk_n or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_fall_reg  <= '0;
			oe_fall_reg <= 1'b0;
		end else begin
			q_fall_reg  <= (mode_reg == DBSP_LAT_ONE_HALF) ? rw0 : rw1;
			oe_fall_reg <= rd_s1_reg;
		end
	end

	// ddr mux on the launch clock level
	assign o_dq = lclk ? q_rise_reg : q_fall_reg;

	assign o_dq_oe = lclk ? oe_rise_reg : oe_fall_reg;

	assign o_echo_strobe   = lclk;
	assign o_echo_strobe_n = lclk_n;

	// ----------------------------------------------------------------
	// access monitor, i_clock domain
	// ----------------------------------------------------------------
	// first flop feeds only the second
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tg_m_reg <= 1'b0;
			tg_s_reg <= 1'b0;
			tg_d_reg <= 1'b0;
		end else begin
			tg_m_reg <= acc_tgl_reg;
			tg_s_reg <= tg_m_reg;
			tg_d_reg <= tg_s_reg;
		end
	end

	// accesses closer than one monitor cycle would merge; ok at these rates
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pulse_reg <= 1'b0;
			count_reg <= DBSP_CNT_RST;
		end else begin
			pulse_reg <= tg_s_reg ^ tg_d_reg;
			if (tg_s_reg ^ tg_d_reg) begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end

	assign o_access_pulse = pulse_reg;
	assign o_access_count = count_reg;

endmodule

/* File: include/dbsp_pkg.sv */
// Purpose: shared constants and types for the burst-of-two ddr memory port
// Assumes: nine-bit byte lanes, two-word bursts
// Notes:   width variants are picked by top-level parameters
package dbsp_pkg;

	// ----------------------------------------------------------------
	// data organisation
	// ----------------------------------------------------------------
	localparam int unsigned DBSP_BYTE_W        = 9;
	localparam int unsigned DBSP_BURST_LEN     = 2;
	localparam int unsigned DBSP_DATA_W_NARROW = 18;
	localparam int unsigned DBSP_DATA_W_WIDE   = 36;
	localparam int unsigned DBSP_ADDR_W_NARROW = 20;
	localparam int unsigned DBSP_ADDR_W_WIDE   = 19;

	// ----------------------------------------------------------------
	// read latency modes, selected by the latency mode pin
	// ----------------------------------------------------------------
	typedef enum logic {
		DBSP_LAT_ONE      = 1'b0,
		DBSP_LAT_ONE_HALF = 1'b1
	} dbsp_lat_t;

	localparam dbsp_lat_t DBSP_LAT_RST = DBSP_LAT_ONE_HALF;

	// ----------------------------------------------------------------
	// access monitor
	// ----------------------------------------------------------------
	localparam int unsigned DBSP_CNT_W   = 16;
	localparam logic [15:0] DBSP_CNT_RST = 16'h0000;

endpackage

/* File: include/dbsp_mem_if.sv */
// Purpose: carrier between the port logic and the two-bank array
// Assumes: one row holds one even and one odd word
// Notes:   write and read ports are independent
`timescale 1ns/10ps
interface dbsp_mem_if #(
	parameter int unsigned DATA_W = 18,
	parameter int unsigned NBYTES = 2,
	parameter int unsigned ROW_W  = 19
);
	logic              wr_en;
	logic [ROW_W-1:0]  wr_row;
	logic [DATA_W-1:0] wr_even;
	logic [DATA_W-1:0] wr_odd;
	logic [NBYTES-1:0] be_even;
	logic [NBYTES-1:0] be_odd;
	logic              rd_en;
	logic [ROW_W-1:0]  rd_row;
	logic [DATA_W-1:0] rd_even;
	logic [DATA_W-1:0] rd_odd;

	modport ctrl (
		output wr_en, wr_row, wr_even, wr_odd, be_even, be_odd, rd_en, rd_row,
		input  rd_even, rd_odd
	);
	modport mem (
		input  wr_en, wr_row, wr_even, wr_odd, be_even, be_odd, rd_en, rd_row,
		output rd_even, rd_odd
	);
endinterface

/* File: core/dbsp_burst_mem.sv */
// Purpose: storage array split in an even and an odd bank
// Assumes: byte enables are active high, one per nine-bit lane
// Notes:   read data sit in a register that only moves on a read
`timescale 1ns/10ps
module dbsp_burst_mem
	import dbsp_pkg::*;
#(
	parameter int unsigned DATA_W = 18,
	parameter int unsigned NBYTES = 2,
	parameter int unsigned ROW_W  = 19
) (
	input wire logic    i_clk,
	dbsp_mem_if.mem     mif
);

	// ----------------------------------------------------------------
	// banks
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] bank_even [0:(2**ROW_W)-1];
	logic [DATA_W-1:0] bank_odd  [0:(2**ROW_W)-1];
	logic [DATA_W-1:0] rd_even_reg;
	logic [DATA_W-1:0] rd_odd_reg;

	// byte lanes left unselected keep their old contents
	always_ff @(posedge i_clk) begin
		if (mif.wr_en) begin
			for (int b = 0; b < NBYTES; b++) begin
				if (mif.be_even[b]) begin
					bank_even[mif.wr_row][b*DBSP_BYTE_W +: DBSP_BYTE_W] <=
						mif.wr_even[b*DBSP_BYTE_W +: DBSP_BYTE_W];
				end
				if (mif.be_odd[b]) begin
					bank_odd[mif.wr_row][b*DBSP_BYTE_W +: DBSP_BYTE_W] <=
						mif.wr_odd[b*DBSP_BYTE_W +: DBSP_BYTE_W];
				end
			end
		end
	end

	// held between reads so both latency modes can pick words late
	always_ff @(posedge i_clk) begin
		if (mif.rd_en) begin
			rd_even_reg <= bank_even[mif.rd_row];
			rd_odd_reg  <= bank_odd[mif.rd_row];
		end
	end

	assign mif.rd_even = rd_even_reg;
	assign mif.rd_odd  = rd_odd_reg;

endmodule

/* File: verification/dbsp_port_sva.sv */
// Purpose: pin assertions for the ddr burst port
// Assumes: bench feeds the output clock pair from the input pair
// Notes:   k-domain helper flops mirror the drop of a second load
`timescale 1ns/10ps
module dbsp_port_sva
	import dbsp_pkg::*;
(
	input wire logic                  i_clock,
	input wire logic                  i_rst_n,
	input wire logic                  i_k_clk,
	input wire logic                  i_c_clk,
	input wire logic                  i_out_clk_sel,
	input wire logic                  i_latency_mode_pin,
	input wire logic                  i_access_load_n,
	input wire logic                  i_rd_wr_n,
	input wire logic                  o_dq_oe,
	input wire logic                  o_echo_strobe,
	input wire logic                  o_echo_strobe_n,
	input wire logic                  o_access_pulse,
	input wire logic [DBSP_CNT_W-1:0] o_access_count
);
	// ----------------------------
	// helper logic and properties
	// ----------------------------
	logic                  take_reg;
	logic                  take_now;
	logic [2:0]            rd_pipe_reg;
	logic [DBSP_CNT_W-1:0] takes_reg;
	// a load right after a taken one is dropped, so it is not counted
	assign take_now = !i_access_load_n && !take_reg;
	always_ff @(posedge i_k_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			take_reg    <= 1'b0;
			rd_pipe_reg <= 3'h0;
			takes_reg   <= 16'h0000;
		end else begin
			take_reg    <= take_now;
			rd_pipe_reg <= {rd_pipe_reg[1:0], take_now && i_rd_wr_n};
			takes_reg   <= takes_reg + {15'h0000, take_now};
		end
	end
	sequence s_caught;
		##[1:6] (takes_reg == o_access_count);
	endsequence
	a_count_catches: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(takes_reg != o_access_count) |-> s_caught) else $error("access count lags taken loads");
	a_pulse_single: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_access_pulse |=> !o_access_pulse) else $error("access pulse too long");
	a_count_step: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_access_pulse |-> o_access_count == $past(o_access_count) + 16'h0001) else $error("count step wrong");
	a_count_still: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!o_access_pulse |-> $stable(o_access_count)) else $error("count moved without pulse");
	a_echo_match: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_echo_strobe == (i_out_clk_sel ? i_c_clk : i_k_clk) && o_echo_strobe_n == !o_echo_strobe)
		else $error("echo clocks off the launch pair");
	a_oe_latency: assert property (@(negedge i_k_clk) disable iff (!i_rst_n)
		rd_pipe_reg[1] |-> o_dq_oe == !i_latency_mode_pin) else $error("read drive at wrong half cycle");
	a_oe_half_on: assert property (@(posedge i_k_clk) disable iff (!i_rst_n)
		rd_pipe_reg[1] && i_latency_mode_pin |-> o_dq_oe) else $error("late read not driven");
	a_oe_idle_low: assert property (@(negedge i_k_clk) disable iff (!i_rst_n)
		rd_pipe_reg == 3'h0 |-> !o_dq_oe) else $error("data driven with no read");
endmodule
bind dbsp_port dbsp_port_sva i_dbsp_port_sva (.i_clock, .i_rst_n, .i_k_clk, .i_c_clk, .i_out_clk_sel,
	.i_latency_mode_pin, .i_access_load_n, .i_rd_wr_n, .o_dq_oe, .o_echo_strobe, .o_echo_strobe_n,
	.o_access_pulse, .o_access_count);

/* File: verification/dbsp_ctrl_model.sv */
// Purpose: memory controller model on the far side of the port
// Assumes: free-running input clock pair
// Notes:   released lines show the inverse of their last value
`timescale 1ns/10ps
module dbsp_ctrl_model
	import dbsp_pkg::*;
#(
	parameter int unsigned DATA_W = DBSP_DATA_W_NARROW,
	parameter int unsigned ADDR_W = DBSP_ADDR_W_NARROW
) (
	input  wire logic                          i_latency_mode_pin,
	input  wire logic [DATA_W-1:0]             i_dq,
	output logic                               o_k_clk,
	output logic                               o_k_clk_n,
	output logic                               o_access_load_n,
	output logic                               o_rd_wr_n,
	output logic [ADDR_W-2:0]                  o_addr,
	output logic                               o_burst_start_bit,
	output logic [DATA_W/DBSP_BYTE_W-1:0]      o_byte_write_sel_n,
	output logic [DATA_W-1:0]                  o_dq
);
	// ----------------------------
	// clock pair and access task
	// ----------------------------
	initial begin
		o_k_clk = 1'b0;
		o_k_clk_n = 1'b1;
		o_access_load_n = 1'b1;
		o_rd_wr_n = 1'b1;
		o_addr = '0;
		o_burst_start_bit = 1'b0;
		o_byte_write_sel_n = '1;
		o_dq = '0;
		// half-ns offset keeps k edges off the monitor clock edges
		#0.5;
		forever begin
			#24;
			o_k_clk = ~o_k_clk;
			o_k_clk_n = ~o_k_clk_n;
		end
	end
	task automatic access(input logic rd, input logic [ADDR_W-2:0] row, input logic sb,
		input logic [DATA_W-1:0] w0, w1, input logic [DATA_W/DBSP_BYTE_W-1:0] s0, s1,
		input logic dbl, output logic [DATA_W-1:0] r0, r1);
		@(posedge o_k_clk);
		#1;
		o_access_load_n = 1'b0;
		o_rd_wr_n = rd;
		o_addr = rd ? row : row;
		o_burst_start_bit = sb;
		@(posedge o_k_clk);
		#1;
		// a load on the next rise is made only when a drop is wanted
		if (dbl) begin
			o_rd_wr_n = 1'b0;
		end else begin
			o_access_load_n = 1'b1;
			o_rd_wr_n = !rd;
		end
		o_addr = ~row;
		o_burst_start_bit = !sb;
		// first word with its selects, taken one rise after the load
		o_dq = w0;
		o_byte_write_sel_n = s0;
		@(posedge o_k_clk);
		#1;
		// second word with its selects, taken on the complement rise
		o_access_load_n = 1'b1;
		o_rd_wr_n = !rd;
		o_dq = w1;
		o_byte_write_sel_n = s1;
		if (!i_latency_mode_pin) begin
			#11;
			r0 = i_dq;
		end
		@(posedge o_k_clk_n);
		#12;
		if (!i_latency_mode_pin) begin
			r1 = i_dq;
		end else begin
			r0 = i_dq;
		end
		o_dq = ~o_dq;
		o_byte_write_sel_n = ~o_byte_write_sel_n;
		if (i_latency_mode_pin) begin
			@(posedge o_k_clk);
			#12;
			r1 = i_dq;
		end
	endtask
endmodule

/* File: verification/dbsp_port_tb_top.sv */
// Purpose: self-checking bench for the ddr burst port
// Assumes: output clock pair tied to the input pair
// Notes:   expected words follow from burst order and selects
`timescale 1ns/10ps
module dbsp_port_tb_top
	import dbsp_pkg::*;
;
	// ----------------------------
	// bench
	// ----------------------------
	localparam int unsigned DW = DBSP_DATA_W_NARROW;
	localparam int unsigned AW = DBSP_ADDR_W_NARROW;
	logic                  i_clock, i_rst_n, out_sel, lat, k, k_n, load_n, rd_wr_n, sb, dq_oe;
	logic [AW-2:0]         addr;
	logic [DW/DBSP_BYTE_W-1:0] sel_n;
	logic [DW-1:0]         ctl_dq, dut_dq, dq_wire;
	logic [DBSP_CNT_W-1:0] count;
	int                    mismatches, check_count, sent;
	// the port owns the pins only while it drives a read
	assign dq_wire = dq_oe ? dut_dq : ctl_dq;
	dbsp_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) i_dbsp_ctrl_model (
		.i_latency_mode_pin(lat), .i_dq(dq_wire), .o_k_clk(k), .o_k_clk_n(k_n), .o_access_load_n(load_n),
		.o_rd_wr_n(rd_wr_n), .o_addr(addr), .o_burst_start_bit(sb), .o_byte_write_sel_n(sel_n), .o_dq(ctl_dq));
	dbsp_port #(.DATA_W(DW), .ADDR_W(AW)) i_dbsp_port (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_k_clk(k), .i_k_clk_n(k_n), .i_c_clk(k), .i_c_clk_n(k_n),
		.i_out_clk_sel(out_sel), .i_latency_mode_pin(lat), .i_access_load_n(load_n), .i_rd_wr_n(rd_wr_n),
		.i_addr(addr), .i_burst_start_bit(sb), .i_byte_write_sel_n(sel_n), .i_dq(dq_wire), .o_dq(dut_dq),
		.o_dq_oe(dq_oe), .o_echo_strobe(), .o_echo_strobe_n(), .o_access_pulse(), .o_access_count(count));
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk_data(input string name, input logic [DW-1:0] exp, got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_count();
		int n;
		n = 0;
		while (count !== sent[DBSP_CNT_W-1:0] && n < 40) begin
			@(negedge i_clock);
			n++;
		end
		check_count++;
		if (count !== sent[DBSP_CNT_W-1:0]) begin
			mismatches++;
			$display("MISMATCH access count expected %0d seen %0d", sent, count);
			summarize();
		end
	endtask
	task automatic acc(input logic rd, input logic [AW-2:0] row, input logic s, input logic [DW-1:0] w0, w1,
		input logic [1:0] s0, s1, input logic dbl, output logic [DW-1:0] r0, r1);
		i_dbsp_ctrl_model.access(rd, row, s, w0, w1, s0, s1, dbl, r0, r1);
		sent++;
	endtask
	task automatic t_modes();
		logic [DW-1:0] w0, w1, r0, r1;
		for (int m = 0; m < 4; m++) begin
			@(negedge i_clock);
			lat = m[0];
			out_sel = m[1];
			repeat (4) @(posedge k);
			w0 = {16'ha5c0, m[1:0]};
			w1 = {16'h3c17, m[1:0]};
			acc(1'b0, {17'h00000, m[1:0]}, m[0], w0, w1, 2'h0, 2'h0, 1'b0, r0, r1);
			// one idle rise so the read does not meet the commit
			@(posedge k);
			acc(1'b1, {17'h00000, m[1:0]}, m[0], '0, '0, 2'h3, 2'h3, 1'b0, r0, r1);
			chk_data("first word", w0, r0);
			chk_data("second word", w1, r1);
			acc(1'b1, {17'h00000, m[1:0]}, !m[0], '0, '0, 2'h3, 2'h3, 1'b0, r0, r1);
			chk_data("swapped first word", w1, r0);
			chk_data("swapped second word", w0, r1);
		end
		chk_count();
	endtask
	task automatic t_bytes();
		logic [DW-1:0] r0, r1;
		acc(1'b0, 19'h00005, 1'b0, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0, 1'b0, r0, r1);
		acc(1'b0, 19'h00005, 1'b0, 18'h00000, 18'h00000, 2'h2, 2'h1, 1'b0, r0, r1);
		@(posedge k);
		acc(1'b1, 19'h00005, 1'b0, '0, '0, 2'h3, 2'h3, 1'b0, r0, r1);
		chk_data("merged word0", 18'h3fe00, r0);
		chk_data("merged word1", 18'h001ff, r1);
	endtask
	task automatic t_drop();
		logic [DW-1:0] r0, r1;
		acc(1'b0, 19'h7fff7, 1'b1, 18'h12345, 18'h2abcd, 2'h0, 2'h0, 1'b0, r0, r1);
		acc(1'b0, 19'h00008, 1'b0, 18'h0aaaa, 18'h15555, 2'h0, 2'h0, 1'b1, r0, r1);
		@(posedge k);
		acc(1'b1, 19'h7fff7, 1'b1, '0, '0, 2'h3, 2'h3, 1'b0, r0, r1);
		chk_data("untouched word0", 18'h12345, r0);
		chk_data("untouched word1", 18'h2abcd, r1);
		acc(1'b1, 19'h00008, 1'b0, '0, '0, 2'h3, 2'h3, 1'b0, r0, r1);
		chk_data("new word0", 18'h0aaaa, r0);
		chk_count();
	endtask
	initial begin
		i_rst_n = 1'b0;
		lat = 1'b1;
		out_sel = 1'b0;
		mismatches = 0;
		check_count = 0;
		sent = 0;
		repeat (6) @(negedge i_clock);
		i_rst_n = 1'b1;
		// latency strap needs two rises after release to settle
		repeat (3) @(posedge k);
		t_modes();
		t_bytes();
		t_drop();
		summarize();
	end
endmodule
